// *** dv/mfid_switches.sv ***
// Model of the switches and contacts wired to the input terminals.
// Assumes the bench changes the wanted levels just after a clock edge.
`timescale 1ns/1ns
module mfid_switches (
  input wire logic mclk, // System clock.
  input wire logic [8:0] want, // Wanted contact levels.
  input wire logic bounce, // Contacts chatter while set.
  output logic [8:0] pins // Levels at the terminals.
);
  // Chatter flips every contact each cycle, so no level ever stands still.
  always_ff @(posedge mclk) begin
    pins <= bounce ? ~pins : want;
  end
endmodule

// *** dv/testbench.sv ***
// Self-checking bench of the multi-function input decoder.
// Assumes mfid_pkg, mfid_top and the switch model are compiled first.
`timescale 1ns/1ns
module testbench;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] rd;
  logic [8:0] want = 9'h000;
  logic bounce = 1'b0;
  logic [8:0] pins;
  logic [31:0] dat_o;
  logic ack, run, rev, f_rst, trip, rs2, hold, sf, pidb, blk, s_st, s_dn, cst;
  logic [3:0] step;
  logic [1:0] ssel;
  logic [15:0] cnt;
  int errors = 0;
  int n_checks = 0;
  int n_srch = 0;
  int n_frst = 0;
  int v;
  integer seed = 32'he42c7210;
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin errors++; \
  $display("MISMATCH %s exp %0h got %0h", nm, ex, gt); end end
  always #10 mclk = ~mclk;
  always @(posedge mclk) if (s_st === 1'b1) n_srch++;
  always @(posedge mclk) if (f_rst === 1'b1) n_frst++;
  mfid_switches mfid_switches_i (.mclk(mclk), .want(want), .bounce(bounce), .pins(pins));
  mfid_top #(.TICK_CYCLES(4)) mfid_top_i (.mclk(mclk), .reset_n(reset_n),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wd), .wb_dat_o(dat_o), .wb_ack_o(ack), .fwd_pin(pins[0]),
    .rev_pin(pins[1]), .multi_input_pin(pins[7:2]), .count_pin(pins[8]),
    .run_cmd(run), .run_rev(rev), .step_index(step), .fault_reset(f_rst),
    .external_fault_trip(trip), .count_value(cnt), .ramp_set2(rs2),
    .ramp_hold(hold), .src_force(sf), .src_sel(ssel), .pid_bypass(pidb),
    .output_block(blk), .search_start(s_st), .search_down(s_dn),
    .cmd_src_terminal(cst));
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (ack !== 1'b1) begin
      errors++;
      end_of_test();
    end
    rd = dat_o;
    cyc <= 1'b0;
    we <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic pin(input logic [8:0] p);
    want <= p;
    repeat (40) @(posedge mclk);
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      want[8] <= 1'b1;
      repeat (3) @(posedge mclk);
      want[8] <= 1'b0;
      repeat (3) @(posedge mclk);
    end
  endtask
  function automatic logic [7:0] obs();
    return {rs2, hold, sf, sf ? ssel : 2'b00, pidb, blk, cst};
  endfunction
  function automatic logic [7:0] exp_of(input int c);
    case (c)
      7: return 8'h80;
      8: return 8'h40;
      9: return 8'h20;
      10: return 8'h28;
      11: return 8'h30;
      13: return 8'h04;
      15, 16: return 8'h02;
      default: return 8'h01;
    endcase
  endfunction
  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, mfid_pkg::ADR_FUNC1 + 8'(4 * i), 32'h0);
      `CHK("func", {24'h0, mfid_pkg::FUNC_RST[8 * i +: 8]}, rd)
    end
    bus(1'b0, mfid_pkg::ADR_WIRING, 32'h0);
    `CHK("wiring", 32'h0, rd)
    bus(1'b0, mfid_pkg::ADR_CONFIRM, 32'h0);
    `CHK("confirm", 32'h5, rd)
    for (int i = 0; i < 6; i++) begin
      v = $random(seed);
      pin({3'b000, v[3:0], 2'b00});
      `CHK("step", v[3:0], step)
      bounce <= 1'b1;
      repeat (8) @(posedge mclk);
      bounce <= 1'b0;
      repeat (30) @(posedge mclk);
      `CHK("chatter", v[3:0], step)
    end
    pin(9'h000);
    bus(1'b1, mfid_pkg::ADR_FUNC1 + 8'h10, 32'h1);
    pin(9'h040);
    `CHK("shared", 4'h1, step)
    pin(9'h000);
    bus(1'b1, mfid_pkg::ADR_FUNC1 + 8'h10, 32'h5);
    pin(9'h080);
    `CHK("trip", 1'b1, trip)
    pin(9'h0C0);
    `CHK("trip set wins", 1'b1, trip)
    pin(9'h000);
    `CHK("trip latched", 1'b1, trip)
    v = n_frst;
    pin(9'h040);
    `CHK("trip reset", 1'b0, trip)
    `CHK("reset pulse", v + 1, n_frst)
    pin(9'h000);
    for (int c = 7; c < 18; c++) begin
      if (c == 12 || c == 14) continue;
      bus(1'b1, mfid_pkg::ADR_FUNC1, 32'(c));
      v = n_srch;
      pin(9'h004);
      `CHK("func on", exp_of(c), obs())
      pin(9'h000);
      `CHK("func off", 8'h00, obs())
      if (c == 15 || c == 16) begin
        `CHK("search", v + 1, n_srch)
        `CHK("search down", c == 16, s_dn)
      end
    end
    bus(1'b1, mfid_pkg::ADR_CTRL, 32'h2);
    repeat (3) @(posedge mclk);
    `CHK("keypad", 1'b0, cst)
    bus(1'b1, mfid_pkg::ADR_FUNC1, 32'h0);
    repeat (3) @(posedge mclk);
    `CHK("param source", 1'b1, cst)
    bus(1'b1, mfid_pkg::ADR_FUNC1, 32'h6);
    pin(9'h004);
    `CHK("clear", 16'h0, cnt)
    pulse(3);
    `CHK("clear hold", 16'h0, cnt)
    pin(9'h000);
    v = $random(seed) & 7;
    pulse(v + 1);
    `CHK("count", 16'(v + 1), cnt)
    want <= 9'h001;
    reset_n <= 1'b0;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    bus(1'b1, mfid_pkg::ADR_CTRL, 32'h1);
    repeat (40) @(posedge mclk);
    `CHK("lockout", 1'b0, run)
    pin(9'h000);
    pin(9'h001);
    `CHK("run fwd", 2'b10, {run, rev})
    pin(9'h003);
    `CHK("both stop", 1'b0, run)
    pin(9'h002);
    `CHK("run rev", 2'b11, {run, rev})
    bus(1'b1, mfid_pkg::ADR_FUNC1, 32'hC);
    pin(9'h006);
    `CHK("estop", 1'b0, run)
    pin(9'h002);
    `CHK("estop held", 1'b0, run)
    pin(9'h000);
    pin(9'h002);
    `CHK("fresh run", 2'b11, {run, rev})
    bus(1'b1, mfid_pkg::ADR_WIRING, 32'h1);
    pin(9'h003);
    `CHK("direction wire", 2'b11, {run, rev})
    bus(1'b1, mfid_pkg::ADR_FUNC1, 32'h7);
    bus(1'b1, mfid_pkg::ADR_WIRING, 32'h2);
    pin(9'h004);
    `CHK("stop wire only", 1'b0, rs2)
    pin(9'h005);
    `CHK("three wire start", 1'b1, run)
    pin(9'h001);
    `CHK("three wire stop", 1'b0, run)
    end_of_test();
  end
endmodule

// *** shared/mfid_pkg.sv ***
// Shared constants of the multi-function input decoder: register map,
// field positions, reset values, function codes and timing.
// Assumes a single 50 MHz clock and a classic Wishbone register bus.
package mfid_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
  localparam logic [15:0] CONFIRM_DEFAULT_MS = 16'h0005;
  localparam logic [15:0] CONFIRM_MIN_MS = 16'h0001;
  localparam logic [15:0] CONFIRM_MAX_MS = 16'h7530;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_WIRING = 8'h00;
  localparam logic [7:0] ADR_FUNC1 = 8'h04;
  localparam logic [7:0] ADR_FUNC6 = 8'h18;
  localparam logic [7:0] ADR_CTRL = 8'h1C;
  localparam logic [7:0] ADR_CONFIRM = 8'h20;
  localparam logic [7:0] ADR_STATUS = 8'h24;
  localparam int CTRL_LOCKOUT_BIT = 0;
  localparam int CTRL_OPSRC_BIT = 1;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] WIRING_RST = 8'h00;

  // ----------------------------------------------------------------
  // Wiring codes and input function codes
  // ----------------------------------------------------------------
  localparam logic [7:0] WIRING_2W_A = 8'h00;
  localparam logic [7:0] WIRING_2W_B = 8'h01;
  localparam logic [7:0] WIRING_3W = 8'h02;
  localparam logic [7:0] F_STEP1 = 8'h01;
  localparam logic [7:0] F_STEP2 = 8'h02;
  localparam logic [7:0] F_STEP3 = 8'h03;
  localparam logic [7:0] F_STEP4 = 8'h04;
  localparam logic [7:0] F_RESET = 8'h05;
  localparam logic [7:0] F_CNT_CLR = 8'h06;
  localparam logic [7:0] F_RAMP2 = 8'h07;
  localparam logic [7:0] F_RAMP_HOLD = 8'h08;
  localparam logic [7:0] F_SRC_VA = 8'h09;
  localparam logic [7:0] F_SRC_CUR = 8'h0A;
  localparam logic [7:0] F_SRC_VB = 8'h0B;
  localparam logic [7:0] F_ESTOP = 8'h0C;
  localparam logic [7:0] F_PID_OFF = 8'h0D;
  localparam logic [7:0] F_EXT_FAULT = 8'h0E;
  localparam logic [7:0] F_BB_UP = 8'h0F;
  localparam logic [7:0] F_BB_DOWN = 8'h10;
  localparam logic [7:0] F_CMD_SRC = 8'h11;
  localparam logic [47:0] FUNC_RST = {8'h0E, 8'h05, 8'h04, 8'h03, 8'h02, 8'h01};

  typedef enum logic [1:0] {SRC_VA, SRC_CUR, SRC_VB} mfid_src_t;
  typedef enum logic [1:0] {RUN_STOP, RUN_FWD, RUN_REV} mfid_run_t;

endpackage

// *** src/mfid_counter.sv ***
// Up counter on the external trigger pin, with a level clear.
// Assumes the clear level comes from logic on the same clock.
`timescale 1ns/1ns
module mfid_counter #(
  parameter int W = 16
) (
  input wire logic mclk, // System clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic trig_pin, // Counter trigger pin, unfiltered.
  input wire logic clear, // Clear level.
  output logic [W-1:0] count // Counter value.
);

  logic meta_r, sync_r, prev_r;
  logic [W-1:0] count_r, count_nxt;

  // The trigger skips the stability filter so that short pulses are counted.
  always_comb begin
    count_nxt = count_r;
    if (clear) begin
      count_nxt = '0; // R7 R8
    end else if (sync_r && !prev_r) begin
      count_nxt = count_r + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
      count_r <= '0;
    end else begin
      meta_r <= trig_pin;
      sync_r <= meta_r;
      prev_r <= sync_r;
      count_r <= count_nxt;
    end
  end

  assign count = count_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  chk_clear_holds: assert property (clear |=> count_r == '0) // R8
    else $error("counter moved while clear was active");

endmodule

// *** src/mfid_debounce.sv ***
// Two-flop synchroniser and stability filter for a group of input pins.
// Assumes a one-cycle millisecond tick from the same clock.
`timescale 1ns/1ns
module mfid_debounce #(
  parameter int N = 8,
  parameter int CW = 16
) (
  input wire logic mclk, // System clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic tick, // One-cycle millisecond enable.
  input wire logic [CW-1:0] confirm_ms, // Confirmation time in ms.
  input wire logic [N-1:0] raw, // Pins from outside.
  output logic [N-1:0] clean // Accepted levels.
);

  logic [N-1:0] meta_r;
  logic [N-1:0] sync_r;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= raw;
      sync_r <= meta_r;
    end
  end

  // A level is accepted at the confirm_ms-th tick that finds it standing; the first such tick may come two cycles after the pin changes, once sync_r has it.
  for (genvar i = 0; i < N; i++) begin : g_in
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic clean_r, clean_nxt;
    always_comb begin
      cnt_nxt = cnt_r;
      clean_nxt = clean_r;
      if (sync_r[i] == clean_r) begin
        cnt_nxt = '0;
      end else if (tick) begin
        if (cnt_r + 1'b1 >= confirm_ms) begin // R21
          clean_nxt = sync_r[i];
          cnt_nxt = '0;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
    end
    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
        cnt_r <= '0;
        clean_r <= 1'b0;
      end else begin
        cnt_r <= cnt_nxt;
        clean_r <= clean_nxt;
      end
    end
    assign clean[i] = clean_r;
  end

endmodule

// *** src/mfid_top.sv ***
// Decoder of run-control terminals and six multi-function inputs.
// Assumes a 50 MHz clock, a classic Wishbone master, raw switch pins.
//
// How it works
// R1: Wiring code 0 and 1 give two-wire variants, 2 gives three-wire control.
// R2: With lockout, a run command already held at power-up is ignored.
// R3: With lockout, running starts only after a low-to-high run terminal edge.
// R4: Input function selectors reset to codes 1, 2, 3, 4, 5 and 14.
// R5: Codes 1 to 4 form a four-bit preset speed index.
// R6: Code 5 is a normally-open fault reset once the cause is gone.
// R7: Code 6 holds the counter value at zero.
// R8: Counter ignores triggers while cleared, counts up after release.
// R9: Code 7 selects the second acceleration and deceleration set.
// R10: Code 8 freezes the ramp; release resumes from the held frequency.
// R11: Codes 9, 10, 11 force the speed source to one analog input.
// R12: Code 12 stops like a stop command; running needs a fresh run.
// R13: Code 13 bypasses PID and uses the master frequency source.
// R14: Code 14 trips an external fault latched until reset.
// R15: Codes 15 and 16 cut the output at once into the blocked state.
// R16: Block release starts a speed search, up for 15, down for 16.
// R17: That speed search runs on release even with the motor stopped.
// R18: Code 17 picks keypad when open, terminals when closed.
// R19: An assigned code 17 overrides the configured command source.
// R20: In three-wire mode input one is the stop wire only.
// R21: Inputs except the counter must stand for the confirmation time.
// R22: A function shared by several inputs is active if any is active.
`timescale 1ns/1ns
module mfid_top #(
  parameter int TICK_CYCLES = mfid_pkg::TICK_CYCLES,
  parameter int CNT_W = 16
) (
  input wire logic mclk, // 50 MHz system clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic wb_cyc_i, // Wishbone cycle.
  input wire logic wb_stb_i, // Wishbone strobe.
  input wire logic wb_we_i, // Wishbone write enable.
  input wire logic [7:0] wb_adr_i, // Wishbone byte address.
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
  input wire logic [31:0] wb_dat_i, // Wishbone write data.
  output logic [31:0] wb_dat_o, // Wishbone read data.
  output logic wb_ack_o, // Wishbone acknowledge.
  input wire logic fwd_pin, // Forward or run terminal.
  input wire logic rev_pin, // Reverse or direction terminal.
  input wire logic [5:0] multi_input_pin, // Multi-function inputs one to six.
  input wire logic count_pin, // Counter trigger terminal.
  output logic run_cmd, // Run request to the drive.
  output logic run_rev, // Requested direction is reverse.
  output logic [3:0] step_index, // Preset speed index.
  output logic fault_reset, // One-cycle fault reset pulse.
  output logic external_fault_trip, // Latched external fault.
  output logic [CNT_W-1:0] count_value, // Displayed counter value.
  output logic ramp_set2, // Second ramp time set selected.
  output logic ramp_hold, // Freeze the ramp.
  output logic src_force, // Speed source forced from an input.
  output logic [1:0] src_sel, // Forced source: voltage a, current, voltage b.
  output logic pid_bypass, // Bypass PID control.
  output logic output_block, // Output cut, blocked state.
  output logic search_start, // One-cycle speed search start.
  output logic search_down, // Search runs downward from the top.
  output logic cmd_src_terminal // Operation commands come from terminals.
);

  // ----------------------------------------------------------------
  // Millisecond tick and input filtering
  // ----------------------------------------------------------------
  logic [15:0] tick_cnt_r, tick_cnt_nxt;
  logic tick_r, tick_nxt;
  logic [7:0] clean;
  logic [15:0] confirm_r;

  always_comb begin
    tick_nxt = 1'b0;
    tick_cnt_nxt = tick_cnt_r + 16'h0001;
    if (tick_cnt_r == 16'(TICK_CYCLES - 1)) begin
      tick_cnt_nxt = '0;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  mfid_debounce #(.N(8), .CW(16)) u_filt (
    .mclk(mclk),
    .reset_n(reset_n),
    .tick(tick_r),
    .confirm_ms(confirm_r),
    .raw({multi_input_pin, rev_pin, fwd_pin}),
    .clean(clean)
  );

  logic fwd, rev;
  logic [5:0] mi;
  assign fwd = clean[0];
  assign rev = clean[1];
  assign mi = clean[7:2];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] wiring_r, wiring_nxt;
  logic [47:0] func_r, func_nxt;
  logic [7:0] ctrl_r, ctrl_nxt;
  logic [15:0] confirm_nxt;
  logic [31:0] rdata_nxt, status;
  logic ack_nxt, req;
  logic [15:0] wr_ms;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  always_comb begin
    wiring_nxt = wiring_r;
    func_nxt = func_r;
    ctrl_nxt = ctrl_r;
    confirm_nxt = confirm_r;
    rdata_nxt = '0;
    ack_nxt = req;
    wr_ms = wb_dat_i[15:0];
    if (wr_ms < mfid_pkg::CONFIRM_MIN_MS) begin
      wr_ms = mfid_pkg::CONFIRM_MIN_MS;
    end else if (wr_ms > mfid_pkg::CONFIRM_MAX_MS) begin
      wr_ms = mfid_pkg::CONFIRM_MAX_MS;
    end
    if (req && wb_we_i && wb_sel_i[0]) begin
      case (wb_adr_i)
        mfid_pkg::ADR_WIRING: wiring_nxt = wb_dat_i[7:0];
        mfid_pkg::ADR_CTRL: ctrl_nxt = wb_dat_i[7:0];
        mfid_pkg::ADR_CONFIRM: confirm_nxt = wb_sel_i[1] ? wr_ms : confirm_r;
        default: wiring_nxt = wiring_r;
      endcase
      for (int i = 0; i < 6; i++) begin
        if (wb_adr_i == mfid_pkg::ADR_FUNC1 + 8'(4 * i)) begin
          func_nxt[i*8 +: 8] = wb_dat_i[7:0];
        end
      end
    end
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        mfid_pkg::ADR_WIRING: rdata_nxt = {24'h000000, wiring_r};
        mfid_pkg::ADR_CTRL: rdata_nxt = {24'h000000, ctrl_r};
        mfid_pkg::ADR_CONFIRM: rdata_nxt = {16'h0000, confirm_r};
        mfid_pkg::ADR_STATUS: rdata_nxt = status;
        default: rdata_nxt = '0;
      endcase
      for (int i = 0; i < 6; i++) begin
        if (wb_adr_i == mfid_pkg::ADR_FUNC1 + 8'(4 * i)) begin
          rdata_nxt = {24'h000000, func_r[i*8 +: 8]};
        end
      end
    end
  end

  // Unmapped addresses still acknowledge; writes drop and reads return zero.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wiring_r <= mfid_pkg::WIRING_RST;
      func_r <= mfid_pkg::FUNC_RST; // R4
      ctrl_r <= mfid_pkg::CTRL_RST;
      confirm_r <= mfid_pkg::CONFIRM_DEFAULT_MS;
      wb_dat_o <= '0;
      wb_ack_o <= 1'b0;
    end else begin
      wiring_r <= wiring_nxt;
      func_r <= func_nxt;
      ctrl_r <= ctrl_nxt;
      confirm_r <= confirm_nxt;
      wb_dat_o <= rdata_nxt;
      wb_ack_o <= ack_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Function decode
  // ----------------------------------------------------------------
  logic three_wire;
  assign three_wire = wiring_r == mfid_pkg::WIRING_3W; // R1
  // Input one never decodes as a function while it is the stop wire.
  function automatic logic fn_on(input logic [7:0] code, input logic [47:0] sel,
                                 input logic [5:0] lvl, input logic skip1);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 6; i++) begin
      if (sel[i*8 +: 8] == code && lvl[i] && !(i == 0 && skip1)) begin // R20
        hit = 1'b1; // R22
      end
    end
    return hit;
  endfunction

  logic f_rst, f_clr, f_r2, f_hold, f_va, f_cur, f_vb, f_estop, f_pid;
  logic f_ef, f_bbu, f_bbd, f_cs, cs_assigned;
  logic [3:0] step;
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      step[b] = fn_on(mfid_pkg::F_STEP1 + 8'(b), func_r, mi, three_wire); // R5
    end
  end
  assign f_rst = fn_on(mfid_pkg::F_RESET, func_r, mi, three_wire);
  assign f_clr = fn_on(mfid_pkg::F_CNT_CLR, func_r, mi, three_wire);
  assign f_r2 = fn_on(mfid_pkg::F_RAMP2, func_r, mi, three_wire);
  assign f_hold = fn_on(mfid_pkg::F_RAMP_HOLD, func_r, mi, three_wire);
  assign f_va = fn_on(mfid_pkg::F_SRC_VA, func_r, mi, three_wire);
  assign f_cur = fn_on(mfid_pkg::F_SRC_CUR, func_r, mi, three_wire);
  assign f_vb = fn_on(mfid_pkg::F_SRC_VB, func_r, mi, three_wire);
  assign f_estop = fn_on(mfid_pkg::F_ESTOP, func_r, mi, three_wire);
  assign f_pid = fn_on(mfid_pkg::F_PID_OFF, func_r, mi, three_wire);
  assign f_ef = fn_on(mfid_pkg::F_EXT_FAULT, func_r, mi, three_wire);
  assign f_bbu = fn_on(mfid_pkg::F_BB_UP, func_r, mi, three_wire);
  assign f_bbd = fn_on(mfid_pkg::F_BB_DOWN, func_r, mi, three_wire);
  assign f_cs = fn_on(mfid_pkg::F_CMD_SRC, func_r, mi, three_wire);
  assign cs_assigned = fn_on(mfid_pkg::F_CMD_SRC, func_r, 6'h3F, three_wire);

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  mfid_pkg::mfid_run_t run_state_r, run_state_nxt;
  logic armed_r, armed_nxt, estop_hold_r, estop_hold_nxt, fwd_prev_r, settled_r, settled_nxt;
  logic [15:0] settle_cnt_r, settle_cnt_nxt;
  logic trip_r, trip_nxt, rst_prev_r, rst_rise, blocked_r, allow, run_lvl;
  assign rst_rise = f_rst && !rst_prev_r;
  assign run_lvl = (wiring_r == mfid_pkg::WIRING_2W_A) ? (fwd || rev) : fwd;
  assign allow = (armed_r || !ctrl_r[mfid_pkg::CTRL_LOCKOUT_BIT]) && !estop_hold_r
                 && !f_estop && !f_ef && !trip_r && !(f_bbu || f_bbd);
  // The filters read low just after reset, so arming waits until they have settled.
  always_comb begin
    settle_cnt_nxt = settle_cnt_r + 16'(tick_r && !settled_r);
    settled_nxt = settled_r || (tick_r && settle_cnt_r >= confirm_r);
    armed_nxt = armed_r || (settled_r && !run_lvl); // R2 R3
    estop_hold_nxt = f_estop || (estop_hold_r && run_lvl); // R12
    run_state_nxt = mfid_pkg::RUN_STOP;
    if (allow) begin
      if (three_wire) begin
        run_state_nxt = run_state_r;
        if (!mi[0]) begin
          run_state_nxt = mfid_pkg::RUN_STOP;
        end else if (fwd && !fwd_prev_r) begin
          run_state_nxt = rev ? mfid_pkg::RUN_REV : mfid_pkg::RUN_FWD;
        end else if (run_state_r != mfid_pkg::RUN_STOP) begin
          run_state_nxt = rev ? mfid_pkg::RUN_REV : mfid_pkg::RUN_FWD;
        end
      end else if (wiring_r == mfid_pkg::WIRING_2W_B) begin
        if (fwd) begin
          run_state_nxt = rev ? mfid_pkg::RUN_REV : mfid_pkg::RUN_FWD;
        end
      end else if (fwd != rev) begin
        run_state_nxt = fwd ? mfid_pkg::RUN_FWD : mfid_pkg::RUN_REV;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      run_state_r <= mfid_pkg::RUN_STOP;
      armed_r <= 1'b0;
      estop_hold_r <= 1'b0;
      fwd_prev_r <= 1'b0;
      settle_cnt_r <= '0;
      settled_r <= 1'b0;
    end else begin
      run_state_r <= run_state_nxt;
      armed_r <= armed_nxt;
      estop_hold_r <= estop_hold_nxt;
      fwd_prev_r <= fwd;
      settle_cnt_r <= settle_cnt_nxt;
      settled_r <= settled_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Fault, output block and command outputs
  // ----------------------------------------------------------------
  logic search_down_nxt;
  mfid_pkg::mfid_src_t src_nxt;
  // A fault that is still present wins over the reset edge.
  assign trip_nxt = f_ef || (trip_r && !rst_rise); // R6 R14
  assign search_down_nxt = (f_bbu || f_bbd) ? !f_bbu : search_down; // R16
  always_comb begin
    src_nxt = mfid_pkg::SRC_VA;
    if (!f_va && f_cur) begin
      src_nxt = mfid_pkg::SRC_CUR;
    end else if (!f_va && f_vb) begin
      src_nxt = mfid_pkg::SRC_VB;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      trip_r <= 1'b0;
      rst_prev_r <= 1'b0;
      blocked_r <= 1'b0;
      run_cmd <= 1'b0;
      run_rev <= 1'b0;
      step_index <= '0;
      fault_reset <= 1'b0;
      ramp_set2 <= 1'b0;
      ramp_hold <= 1'b0;
      src_force <= 1'b0;
      src_sel <= mfid_pkg::SRC_VA;
      pid_bypass <= 1'b0;
      search_start <= 1'b0;
      search_down <= 1'b0;
      cmd_src_terminal <= 1'b0;
    end else begin
      trip_r <= trip_nxt;
      rst_prev_r <= f_rst;
      blocked_r <= f_bbu || f_bbd; // R15
      run_cmd <= run_state_nxt != mfid_pkg::RUN_STOP;
      run_rev <= run_state_nxt == mfid_pkg::RUN_REV;
      step_index <= step; // R5
      fault_reset <= rst_rise; // R6
      ramp_set2 <= f_r2; // R9
      ramp_hold <= f_hold; // R10
      src_force <= f_va || f_cur || f_vb; // R11
      src_sel <= src_nxt;
      pid_bypass <= f_pid; // R13
      search_start <= blocked_r && !(f_bbu || f_bbd); // R16 R17
      search_down <= search_down_nxt;
      cmd_src_terminal <= cs_assigned ? f_cs : ctrl_r[mfid_pkg::CTRL_OPSRC_BIT]; // R18 R19
    end
  end

  assign external_fault_trip = trip_r;
  assign output_block = blocked_r;
  assign status = {16'h0000, 4'h0, trip_r, blocked_r, run_cmd, run_rev, clean};

  mfid_counter #(.W(CNT_W)) u_count (
    .mclk(mclk),
    .reset_n(reset_n),
    .trig_pin(count_pin),
    .clear(f_clr), // R7
    .count(count_value)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  chk_fault_latch: assert property (trip_r && !rst_rise |=> trip_r) // R14
    else $error("external fault dropped without reset");
  chk_fault_set: assert property (f_ef |=> trip_r && !run_cmd) // R14
    else $error("external fault did not trip");
  chk_lockout_gate: assert property (ctrl_r[mfid_pkg::CTRL_LOCKOUT_BIT] && !armed_r // R2
                                     |=> !run_cmd)
    else $error("run issued before lockout cleared");
  chk_block_cut: assert property ((f_bbu || f_bbd) |=> output_block && !run_cmd) // R15
    else $error("output not cut on block");
  chk_search_release: assert property (output_block && !(f_bbu || f_bbd) // R16
                                       |=> search_start ##1 !search_start)
    else $error("speed search not pulsed on release");
  chk_estop_fresh: assert property (f_estop ##1 run_lvl [*2] |=> !run_cmd) // R12
    else $error("run resumed without fresh command");
  chk_mi1_reserved: assert property (three_wire && mi[5:1] == 5'h00 |=> step_index == 4'h0) // R20
    else $error("input one decoded in three-wire mode");
  chk_cmd_source: assert property (!cs_assigned |=> // R19
                                   cmd_src_terminal == $past(ctrl_r[mfid_pkg::CTRL_OPSRC_BIT]))
    else $error("command source ignored configuration");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held longer than one cycle");

endmodule
